/* File: logic/fpu_par_pkg.sv */
`default_nettype none
package fpu_par_pkg;
    // apb register offsets
    localparam logic [7:0] OFF_STF = 8'h00;
    localparam logic [7:0] OFF_INT_STAT = 8'h04;
    localparam logic [7:0] OFF_INT_MASK = 8'h08;
    localparam logic [7:0] OFF_RB = 8'h0c;
    localparam logic [7:0] OFF_RA = 8'h10;
    // interrupt status / mask bit positions
    localparam int INT_OVF = 0;
    localparam int INT_UNF = 1;
    localparam int INT_W = 2;
    localparam logic [1:0] INT_MASK_RST = 2'h0;
    localparam logic [6:0] STF_RST = 7'h00;
    localparam logic [31:0] RB_RST = 32'h0000_0000;
    // fixed instruction words
    localparam logic [15:0] OPC_PUSH_RB = 16'hfff0;
    localparam logic [15:0] OPC_POP_RB = 16'hfff1;
    localparam logic [15:0] OPC_RESTORE = 16'he562;
    // condition_field codes
    localparam logic [3:0] COND_NONZERO = 4'h0;
    localparam logic [3:0] COND_ZERO = 4'h1;
    localparam logic [3:0] COND_POSITIVE = 4'h2;
    localparam logic [3:0] COND_NOT_NEG = 4'h3;
    localparam logic [3:0] COND_NEGATIVE = 4'h4;
    localparam logic [3:0] COND_NOT_POS = 4'h5;
    localparam logic [3:0] COND_TEST_SET = 4'ha;
    localparam logic [3:0] COND_TEST_CLEAR = 4'hb;
    localparam logic [3:0] COND_UNDERFLOW_LATCHED = 4'hc;
    localparam logic [3:0] COND_OVERFLOW_LATCHED = 4'hd;
    localparam logic [3:0] COND_ALWAYS = 4'he;
    localparam logic [3:0] ALWAYS_WITH_FLAG_UPDATE = 4'hf;
    // float format
    localparam logic signed [9:0] EXP_BIAS = 10'sd127;
    localparam logic signed [9:0] EXP_MAX = 10'sd255;

    typedef enum logic [2:0] {
        OP_NONE, OP_MUL_STORE, OP_MUL_SUB, OP_COND_NEG, OP_SAVE, OP_LOAD
    } op_e;

    typedef struct packed {
        logic tf;
        logic zi;
        logic ni;
        logic zf;
        logic nf;
        logic latched_underflow_flag;
        logic latched_overflow_flag;
    } stf_s;

    typedef struct packed {
        logic valid;
        op_e kind;
        logic [15:0] lsw;
        logic [2:0] ra;
        logic [2:0] rb;
        logic [2:0] rc;
        logic [2:0] rd;
        logic [2:0] re;
        logic [2:0] rf;
        logic [3:0] cond;
        logic [31:0] addr;
        logic [31:0] data;
    } issue_s;

    typedef struct packed {
        logic we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_s;

    typedef struct packed {
        logic push;
        logic [31:0] wdata;
    } stack_s;
endpackage
`default_nettype wire

/* File: logic/float_mul.sv */
`default_nettype none
module float_mul (
    input wire logic [31:0] a,
    input wire logic [31:0] b,
    output logic [31:0] y,
    output logic ovf,
    output logic unf
);
    logic sign;
    logic [47:0] prod;
    logic signed [9:0] e;
    logic [22:0] frac;

    // truncating multiply, zero and subnormal inputs flush to zero
    always_comb begin
        sign = a[31] ^ b[31];
        prod = {1'b1, a[22:0]} * {1'b1, b[22:0]};
        e = $signed({2'b00, a[30:23]}) + $signed({2'b00, b[30:23]})
            - fpu_par_pkg::EXP_BIAS;
        frac = prod[45:23];
        if (prod[47]) begin
            frac = prod[46:24];
            e = e + 10'sd1;
        end
        ovf = 1'b0;
        unf = 1'b0;
        y = {sign, e[7:0], frac};
        if (a[30:23] == 8'h00 || b[30:23] == 8'h00) begin
            y = {sign, 31'h0};
        end else if (e >= fpu_par_pkg::EXP_MAX) begin
            ovf = 1'b1;
            y = {sign, 8'hff, 23'h0};
        end else if (e <= 10'sd0) begin
            unf = 1'b1;
            y = {sign, 31'h0};
        end
    end
endmodule // float_mul
`default_nettype wire

/* File: logic/float_add.sv */
`default_nettype none
module float_add (
    input wire logic [31:0] a,
    input wire logic [31:0] b,
    output logic [31:0] y,
    output logic ovf,
    output logic unf
);
    logic big_a;
    logic sb;
    logic found;
    logic [7:0] eb;
    logic [7:0] es;
    logic [7:0] d;
    logic [23:0] mb;
    logic [23:0] ms;
    logic [23:0] msh;
    logic [24:0] sum;
    logic [4:0] lz;
    logic signed [9:0] e;

    // align smaller operand, add or subtract, renormalise, truncate
    always_comb begin
        big_a = a[30:0] >= b[30:0];
        eb = big_a ? a[30:23] : b[30:23];
        es = big_a ? b[30:23] : a[30:23];
        sb = big_a ? a[31] : b[31];
        mb = (eb == 8'h00) ? 24'h0 : {1'b1, big_a ? a[22:0] : b[22:0]};
        ms = (es == 8'h00) ? 24'h0 : {1'b1, big_a ? b[22:0] : a[22:0]};
        d = eb - es;
        msh = (d > 8'd23) ? 24'h0 : ms >> d;
        e = $signed({2'b00, eb});
        if (a[31] == b[31]) begin
            sum = {1'b0, mb} + {1'b0, msh};
        end else begin
            sum = {1'b0, mb} - {1'b0, msh};
        end
        if (sum[24]) begin
            sum = sum >> 1;
            e = e + 10'sd1;
        end
        lz = 5'h0;
        found = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            if (!found && sum[i]) begin
                lz = 5'(23 - i);
                found = 1'b1;
            end
        end
        sum = sum << lz;
        e = e - $signed({5'h0, lz});
        ovf = 1'b0;
        unf = 1'b0;
        y = {sb, e[7:0], sum[22:0]};
        if (!found) begin
            y = 32'h0;
        end else if (e >= fpu_par_pkg::EXP_MAX) begin
            ovf = 1'b1;
            y = {sb, 8'hff, 23'h0};
        end else if (e <= 10'sd0) begin
            unf = 1'b1;
            y = {sb, 31'h0};
        end
    end
endmodule // float_add
`default_nettype wire

/* File: logic/fpu_par_ops.sv */
`default_nettype none
module fpu_par_ops (
    input wire logic CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire fpu_par_pkg::issue_s ISSUE,
    output fpu_par_pkg::mem_s MEM,
    output fpu_par_pkg::stack_s STACK,
    output logic STACK_POP,
    input wire logic [31:0] STACK_RDATA,
    input wire logic INT_ENTRY,
    input wire logic INT_RETURN,
    input wire logic REPEAT_START,
    input wire logic REPEAT_END,
    output logic STALL,
    output fpu_par_pkg::stf_s FLOAT_STATUS_REGISTER,
    output logic IRQ
);
    typedef struct packed {
        logic [7:0][31:0] fr;
        logic [7:0][31:0] sh;
        fpu_par_pkg::stf_s float_status_register;
        fpu_par_pkg::stf_s sh_stf;
        logic [31:0] rb;
        logic ra;
        logic ras;
        logic p_valid;
        logic p_sub;
        logic p_ovf;
        logic p_unf;
        logic [2:0] p_mdst;
        logic [2:0] p_sdst;
        logic [31:0] p_mul;
        logic [31:0] p_dif;
        fpu_par_pkg::mem_s mem;
        fpu_par_pkg::stack_s stk;
        logic [1:0] istat;
        logic [1:0] imask;
        logic [31:0] prdata;
        logic push_done;
        logic stall;
    } state_s;

    state_s st_reg;
    state_s st_next;
    logic [31:0] mul_a;
    logic [31:0] mul_y;
    logic [31:0] dif_y;
    logic mul_ovf;
    logic mul_unf;
    logic dif_ovf;
    logic dif_unf;
    logic cond_true;
    logic [31:0] neg_src;
    logic [31:0] neg_res;
    logic is_push;
    logic is_pop;
    logic is_restore;
    logic is_mul;
    logic acc_wr;
    logic acc_rd;
    logic mapped;
    logic [1:0] ev;

    // mul operands: store form uses rd<=re*rf, subtract form ra<=rb*rc
    assign mul_a = (ISSUE.kind == fpu_par_pkg::OP_MUL_SUB) ?
        st_reg.fr[ISSUE.rb] : st_reg.fr[ISSUE.re];

    float_mul u_mul (
        .a(mul_a),
        .b((ISSUE.kind == fpu_par_pkg::OP_MUL_SUB) ?
            st_reg.fr[ISSUE.rc] : st_reg.fr[ISSUE.rf]),
        .y(mul_y),
        .ovf(mul_ovf),
        .unf(mul_unf)
    );

    float_add u_sub (
        .a(st_reg.fr[ISSUE.re]),
        .b({~st_reg.fr[ISSUE.rf][31], st_reg.fr[ISSUE.rf][30:0]}),
        .y(dif_y),
        .ovf(dif_ovf),
        .unf(dif_unf)
    );

    assign is_push = ISSUE.valid && ISSUE.lsw == fpu_par_pkg::OPC_PUSH_RB;
    assign is_pop = ISSUE.valid && ISSUE.lsw == fpu_par_pkg::OPC_POP_RB;
    assign is_restore = ISSUE.valid &&
        ISSUE.lsw == fpu_par_pkg::OPC_RESTORE;
    assign is_mul = ISSUE.valid &&
        (ISSUE.kind == fpu_par_pkg::OP_MUL_STORE ||
         ISSUE.kind == fpu_par_pkg::OP_MUL_SUB);
    assign neg_src = st_reg.fr[ISSUE.rb];
    assign acc_wr = PSEL && PENABLE && PWRITE;
    assign acc_rd = PSEL && !PENABLE && !PWRITE;
    assign mapped = PADDR == fpu_par_pkg::OFF_STF ||
        PADDR == fpu_par_pkg::OFF_INT_STAT ||
        PADDR == fpu_par_pkg::OFF_INT_MASK ||
        PADDR == fpu_par_pkg::OFF_RB || PADDR == fpu_par_pkg::OFF_RA;

    // condition_field decode against current status
    always_comb begin
        unique case (ISSUE.cond)
            fpu_par_pkg::COND_NONZERO: cond_true = !st_reg.float_status_register.zf;
            fpu_par_pkg::COND_ZERO: cond_true = st_reg.float_status_register.zf;
            fpu_par_pkg::COND_POSITIVE:
                cond_true = !st_reg.float_status_register.zf && !st_reg.float_status_register.nf;
            fpu_par_pkg::COND_NOT_NEG: cond_true = !st_reg.float_status_register.nf;
            fpu_par_pkg::COND_NEGATIVE: cond_true = st_reg.float_status_register.nf;
            fpu_par_pkg::COND_NOT_POS:
                cond_true = st_reg.float_status_register.zf && st_reg.float_status_register.nf;
            fpu_par_pkg::COND_TEST_SET: cond_true = st_reg.float_status_register.tf;
            fpu_par_pkg::COND_TEST_CLEAR: cond_true = !st_reg.float_status_register.tf;
            fpu_par_pkg::COND_UNDERFLOW_LATCHED:
                cond_true = st_reg.float_status_register.latched_underflow_flag;
            fpu_par_pkg::COND_OVERFLOW_LATCHED:
                cond_true = st_reg.float_status_register.latched_overflow_flag;
            fpu_par_pkg::COND_ALWAYS,
            fpu_par_pkg::ALWAYS_WITH_FLAG_UPDATE: cond_true = 1'b1;
            default: cond_true = 1'b0;
        endcase
    end

    assign neg_res = cond_true ?
        {~neg_src[31], neg_src[30:0]} : neg_src;

    always_comb begin
        st_next = st_reg;
        ev = 2'h0;
        st_next.mem.we = 1'b0;
        st_next.stk.push = 1'b0;
        st_next.stall = 1'b0;
        st_next.p_valid = 1'b0;
        // second pipeline stage: retire multiply and subtract
        if (st_reg.p_valid) begin
            st_next.fr[st_reg.p_mdst] = st_reg.p_mul;
            if (st_reg.p_sub) begin
                st_next.fr[st_reg.p_sdst] = st_reg.p_dif;
            end
            if (st_reg.p_ovf) begin
                st_next.float_status_register.latched_overflow_flag = 1'b1;
                ev[fpu_par_pkg::INT_OVF] = 1'b1;
            end
            if (st_reg.p_unf) begin
                st_next.float_status_register.latched_underflow_flag = 1'b1;
                ev[fpu_par_pkg::INT_UNF] = 1'b1;
            end
        end
        // first stage
        if (is_mul) begin
            st_next.p_valid = 1'b1;
            st_next.p_mul = mul_y;
            st_next.p_dif = dif_y;
            st_next.p_sub = ISSUE.kind == fpu_par_pkg::OP_MUL_SUB;
            st_next.p_mdst = st_next.p_sub ? ISSUE.ra : ISSUE.rd;
            st_next.p_sdst = ISSUE.rd;
            st_next.p_ovf = mul_ovf || (st_next.p_sub && dif_ovf);
            st_next.p_unf = mul_unf || (st_next.p_sub && dif_unf);
            if (!st_next.p_sub) begin
                st_next.mem.we = 1'b1;
                st_next.mem.addr = ISSUE.addr;
                st_next.mem.wdata = st_reg.fr[ISSUE.ra];
            end
        end
        if (ISSUE.valid && ISSUE.kind == fpu_par_pkg::OP_COND_NEG) begin
            st_next.fr[ISSUE.ra] = neg_res;
            if (ISSUE.cond == fpu_par_pkg::ALWAYS_WITH_FLAG_UPDATE) begin
                st_next.float_status_register.nf = neg_res[31];
                st_next.float_status_register.zf = 1'b0;
                if (neg_res[30:23] == 8'h00) begin
                    st_next.float_status_register.zf = 1'b1;
                    st_next.float_status_register.nf = 1'b0;
                end
                st_next.float_status_register.ni = neg_res[31];
                st_next.float_status_register.zi = neg_res == 32'h0;
            end
        end
        if (ISSUE.valid && ISSUE.kind == fpu_par_pkg::OP_LOAD) begin
            st_next.fr[ISSUE.ra] = ISSUE.data;
        end
        if (ISSUE.valid && ISSUE.kind == fpu_par_pkg::OP_SAVE) begin
            st_next.sh = st_reg.fr;
            st_next.sh_stf = st_reg.float_status_register;
        end
        if (is_restore) begin
            st_next.fr = st_reg.sh;
            st_next.float_status_register = st_reg.sh_stf;
        end
        if (is_pop) begin
            st_next.rb = STACK_RDATA;
        end
        if (is_push) begin
            st_next.stk.push = 1'b1;
            st_next.stk.wdata = st_reg.rb;
            // in a repeat block only the first pass pays a cycle; every push outside one pays it too
            st_next.stall = !st_reg.push_done;
            st_next.push_done = st_reg.ra;
        end
        // repeat active bit and its shadow
        if (REPEAT_START) begin
            st_next.ra = 1'b1;
        end
        if (REPEAT_END) begin
            st_next.ra = 1'b0;
        end
        if (INT_ENTRY) begin
            st_next.ras = st_reg.ra;
            st_next.ra = 1'b0;
        end else if (INT_RETURN) begin
            st_next.ra = st_reg.ras;
            st_next.ras = 1'b0;
        end
        if (!st_next.ra) begin
            st_next.push_done = 1'b0;
        end
        // apb writes; hardware events win over write-one-to-clear
        if (acc_wr && PADDR == fpu_par_pkg::OFF_STF) begin
            st_next.float_status_register = PWDATA[6:0];
        end
        // latched flags raised this cycle survive a status write
        if (ev[fpu_par_pkg::INT_OVF]) begin
            st_next.float_status_register.latched_overflow_flag = 1'b1;
        end
        if (ev[fpu_par_pkg::INT_UNF]) begin
            st_next.float_status_register.latched_underflow_flag = 1'b1;
        end
        if (acc_wr && PADDR == fpu_par_pkg::OFF_INT_MASK) begin
            st_next.imask = PWDATA[1:0];
        end
        st_next.istat = st_reg.istat;
        if (acc_wr && PADDR == fpu_par_pkg::OFF_INT_STAT) begin
            st_next.istat = st_reg.istat & ~PWDATA[1:0];
        end
        st_next.istat = st_next.istat | ev;
        if (acc_rd) begin
            unique case (PADDR)
                fpu_par_pkg::OFF_STF: st_next.prdata = {25'h0, st_reg.float_status_register};
                fpu_par_pkg::OFF_INT_STAT:
                    st_next.prdata = {30'h0, st_reg.istat};
                fpu_par_pkg::OFF_INT_MASK:
                    st_next.prdata = {30'h0, st_reg.imask};
                fpu_par_pkg::OFF_RB: st_next.prdata = st_reg.rb;
                fpu_par_pkg::OFF_RA:
                    st_next.prdata = {30'h0, st_reg.ras, st_reg.ra};
                default: st_next.prdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st_reg <= '0;
            st_reg.float_status_register <= fpu_par_pkg::STF_RST;
            st_reg.rb <= fpu_par_pkg::RB_RST;
            st_reg.imask <= fpu_par_pkg::INT_MASK_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign PRDATA = st_reg.prdata;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !mapped;
    assign MEM = st_reg.mem;
    assign STACK = st_reg.stk;
    assign STACK_POP = is_pop;
    assign STALL = st_reg.stall;
    assign FLOAT_STATUS_REGISTER = st_reg.float_status_register;
    assign IRQ = |(st_reg.istat & st_reg.imask);

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    mul_two_cycle_a: assert property (
        is_mul && ISSUE.kind == fpu_par_pkg::OP_MUL_STORE |-> ##2
        st_reg.fr[$past(ISSUE.rd, 2)] == $past(mul_y, 2))
        else $error("multiply result not written two cycles after issue");
    store_next_cycle_a: assert property (
        is_mul && ISSUE.kind == fpu_par_pkg::OP_MUL_STORE |=>
        MEM.we && MEM.wdata == $past(st_reg.fr[ISSUE.ra]) &&
        MEM.addr == $past(ISSUE.addr) ##1 !MEM.we || $past(is_mul))
        else $error("parallel store not done one cycle after issue");
    ovf_latched_a: assert property (
        is_mul && mul_ovf && !acc_wr && !is_restore ##1 !acc_wr &&
        !(ISSUE.valid && ISSUE.kind == fpu_par_pkg::OP_COND_NEG) |=>
        FLOAT_STATUS_REGISTER.latched_overflow_flag && FLOAT_STATUS_REGISTER.zf == $past(FLOAT_STATUS_REGISTER.zf, 2) &&
        FLOAT_STATUS_REGISTER.nf == $past(FLOAT_STATUS_REGISTER.nf, 2) && FLOAT_STATUS_REGISTER.tf == $past(FLOAT_STATUS_REGISTER.tf, 2))
        else $error("overflow not latched or other flags changed");
    unf_latched_a: assert property (
        is_mul && mul_unf && !is_restore ##1 !acc_wr |=> FLOAT_STATUS_REGISTER.latched_underflow_flag)
        else $error("underflow not latched");
    sub_two_cycle_a: assert property (
        ISSUE.valid && ISSUE.kind == fpu_par_pkg::OP_MUL_SUB |-> ##2
        st_reg.fr[$past(ISSUE.rd, 2)] == $past(dif_y, 2))
        else $error("difference not written two cycles after issue");
    cond_both_a: assert property (
        ISSUE.valid && ISSUE.kind == fpu_par_pkg::OP_COND_NEG &&
        ISSUE.cond == fpu_par_pkg::COND_NOT_POS && !is_restore |=>
        st_reg.fr[$past(ISSUE.ra)] == ($past(neg_src) ^
        {$past(FLOAT_STATUS_REGISTER.zf && FLOAT_STATUS_REGISTER.nf), 31'h0}))
        else $error("code 0101 decoded wrongly");
    cond_positive_a: assert property (
        ISSUE.valid && ISSUE.kind == fpu_par_pkg::OP_COND_NEG &&
        ISSUE.cond == fpu_par_pkg::COND_POSITIVE && !is_restore |=>
        st_reg.fr[$past(ISSUE.ra)] == ($past(neg_src) ^
        {$past(!FLOAT_STATUS_REGISTER.zf && !FLOAT_STATUS_REGISTER.nf), 31'h0}))
        else $error("code 0010 decoded wrongly");
    neg_keep_flags_a: assert property (
        ISSUE.valid && ISSUE.kind == fpu_par_pkg::OP_COND_NEG &&
        ISSUE.cond != fpu_par_pkg::ALWAYS_WITH_FLAG_UPDATE &&
        !acc_wr && !is_restore |=> $stable(FLOAT_STATUS_REGISTER.zf) && $stable(FLOAT_STATUS_REGISTER.nf) &&
        $stable(FLOAT_STATUS_REGISTER.zi) && $stable(FLOAT_STATUS_REGISTER.ni))
        else $error("conditional negate changed result flags");
    pop_reload_a: assert property (
        is_pop && !st_reg.p_valid && !acc_wr && !is_restore |=>
        st_reg.rb == $past(STACK_RDATA) && $stable(FLOAT_STATUS_REGISTER))
        else $error("pop did not reload repeat block cleanly");
    ra_shadow_a: assert property (
        INT_ENTRY && !REPEAT_START |=> !st_reg.ra &&
        st_reg.ras == $past(st_reg.ra))
        else $error("interrupt entry did not shadow repeat active");
    restore_all_a: assert property (
        is_restore && !acc_wr |=> FLOAT_STATUS_REGISTER == $past(st_reg.sh_stf) &&
        st_reg.fr == $past(st_reg.sh))
        else $error("restore did not reload from shadow");

    mul_store_c: cover property (
        is_mul && ISSUE.kind == fpu_par_pkg::OP_MUL_STORE ##2 1);
    mul_sub_ovf_c: cover property (
        ISSUE.kind == fpu_par_pkg::OP_MUL_SUB && is_mul && mul_ovf ##2 IRQ);
    neg_update_c: cover property (
        ISSUE.valid && ISSUE.kind == fpu_par_pkg::OP_COND_NEG &&
        ISSUE.cond == fpu_par_pkg::ALWAYS_WITH_FLAG_UPDATE);
    push_repeat_c: cover property (is_push && st_reg.push_done);
endmodule // fpu_par_ops
`default_nettype wire

/* File: tb/fpu_host_model.sv */
`default_nettype none
module fpu_host_model #(
    parameter logic [31:0] SEED_WORD = 32'h5a3c_0f96
) (
    input wire logic CLK,
    input wire logic RST,
    input wire fpu_par_pkg::stack_s STACK,
    input wire logic STACK_POP,
    output logic [31:0] STACK_RDATA
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] stk [0:15];
    logic [3:0] sp;
    logic [31:0] last;
    // service code keeps the repeat block word here while masked
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            sp <= 4'h1;
            stk[0] <= SEED_WORD;
            last <= 32'h0;
        end else if (STACK.push) begin
            stk[sp] <= STACK.wdata;
            sp <= sp + 4'h1;
        end else if (STACK_POP) begin
            sp <= sp - 4'h1;
            last <= stk[sp - 4'h1];
        end
    end
    // bus shows the inverse of the last popped word outside a pop
    assign STACK_RDATA = STACK_POP ? stk[sp - 4'h1] : ~last;
endmodule // fpu_host_model
`default_nettype wire

/* File: tb/tb.sv */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] SEED = 32'h5a3c_0f96;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0] pa = 8'h00;
    logic [31:0] pwd = 32'h0, prd, srd;
    logic pready, serr, perr, irq, stall, spop;
    logic [3:0] ctl = 4'h0;
    fpu_par_pkg::issue_s iss = '0;
    fpu_par_pkg::mem_s mem;
    fpu_par_pkg::stack_s stk;
    fpu_par_pkg::stf_s float_status_register;
    int fails = 0, n_compared = 0, cyc = 0;
    fpu_par_ops fpu_par_ops_inst (.CLK(CLK), .RST(RST), .PSEL(psel),
        .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd),
        .PRDATA(prd), .PREADY(pready), .PSLVERR(serr), .ISSUE(iss),
        .MEM(mem), .STACK(stk), .STACK_POP(spop), .STACK_RDATA(srd),
        .INT_ENTRY(ctl[3]), .INT_RETURN(ctl[2]), .REPEAT_START(ctl[1]),
        .REPEAT_END(ctl[0]), .STALL(stall), .FLOAT_STATUS_REGISTER(float_status_register), .IRQ(irq));
    fpu_host_model #(.SEED_WORD(SEED)) fpu_host_model_inst (.CLK(CLK),
        .RST(RST), .STACK(stk), .STACK_POP(spop), .STACK_RDATA(srd));
    always #4 CLK = ~CLK;
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            give_verdict();
        end
    end
    task give_verdict();
        if (fails == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %0t got %h want %h", $time, s, e);
        end
    endtask
    task ap(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
        @(posedge CLK);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge CLK);
        pen <= 1'b1;
        do @(posedge CLK); while (pready !== 1'b1);
        q = prd;
        perr = serr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ap(1'b1, a, d, q);
        @(negedge CLK);
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        ap(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task go(input fpu_par_pkg::issue_s x);
        x.valid = 1'b1;
        @(posedge CLK);
        iss <= x;
        @(posedge CLK);
        iss.valid <= 1'b0;
    endtask
    task pl(input logic [3:0] m);
        @(posedge CLK);
        ctl <= m;
        @(posedge CLK);
        ctl <= 4'h0;
    endtask
    // register nibbles: ra rb rc rd re rf
    function automatic fpu_par_pkg::issue_s op(input fpu_par_pkg::op_e k,
            input logic [23:0] r, input logic [3:0] c, input logic [15:0] w);
        op = '0;
        op.kind = k;
        {op.ra, op.rb, op.rc} = {r[22:20], r[18:16], r[14:12]};
        {op.rd, op.re, op.rf} = {r[10:8], r[6:4], r[2:0]};
        op.cond = c;
        op.lsw = w;
        op.addr = $urandom;
    endfunction
    task ld(input logic [2:0] r, input logic [31:0] v);
        fpu_par_pkg::issue_s x;
        x = op(fpu_par_pkg::OP_LOAD, {1'b0, r, 20'h0}, 4'h0, 16'h0);
        x.data = v;
        go(x);
    endtask
    task stx(input fpu_par_pkg::issue_s x, input logic [31:0] e);
        go(x);
        @(negedge CLK);
        chk({31'h0, mem.we}, 32'h1);
        chk(mem.addr, x.addr);
        chk(mem.wdata, e);
    endtask
    // store via a 0*0 multiply into the scratch register
    task st(input logic [2:0] r, input logic [31:0] e);
        stx(op(fpu_par_pkg::OP_MUL_STORE, {1'b0, r, 20'h00700}, 4'h0,
            16'h0), e);
    endtask
    function automatic logic cnd(input logic [3:0] c,
            input fpu_par_pkg::stf_s f);
        case (c)
            4'h0: return !f.zf;
            4'h1: return f.zf;
            4'h2: return !f.zf && !f.nf;
            4'h3: return !f.nf;
            4'h4: return f.nf;
            4'h5: return f.zf && f.nf;
            4'ha: return f.tf;
            4'hb: return !f.tf;
            4'hc: return f.latched_underflow_flag;
            4'hd: return f.latched_overflow_flag;
            4'he, 4'hf: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction
    function automatic logic [6:0] upd(input logic [6:0] s,
            input logic [31:0] w);
        fpu_par_pkg::stf_s f;
        f = s;
        f.nf = w[31] && (w[30:23] != 8'h00);
        f.zf = (w[30:23] == 8'h00);
        f.ni = w[31];
        f.zi = (w == 32'h0);
        return f;
    endfunction
    initial begin
        logic [31:0] v, e;
        logic [6:0] s;
        void'($urandom(21765));
        repeat (16) @(posedge CLK);
        RST <= 1'b0;
        rdc(fpu_par_pkg::OFF_STF, 32'h0);
        rdc(fpu_par_pkg::OFF_INT_MASK, 32'h0);
        wr(fpu_par_pkg::OFF_RB, 32'hffff_ffff);
        rdc(fpu_par_pkg::OFF_RB, 32'h0);
        rdc(8'h40, 32'h0);
        chk({31'h0, perr}, 32'h1);
        wr(fpu_par_pkg::OFF_INT_MASK, 32'h3);
        ld(3'h1, 32'h4000_0000);
        ld(3'h2, 32'h4040_0000);
        go(op(fpu_par_pkg::OP_MUL_SUB, 24'h312421, 4'h0, 16'h0));
        st(3'h3, 32'h40c0_0000);
        st(3'h4, 32'h3f80_0000);
        stx(op(fpu_par_pkg::OP_MUL_STORE, 24'h100512, 4'h0, 16'h0),
            32'h4000_0000);
        st(3'h5, 32'h40c0_0000);
        ld(3'h1, 32'h7f00_0000);
        wr(fpu_par_pkg::OFF_STF, 32'h7c);
        go(op(fpu_par_pkg::OP_MUL_STORE, 24'h000511, 4'h0, 16'h0));
        @(negedge CLK);
        chk({25'h0, float_status_register}, 32'h7c);
        @(negedge CLK);
        chk({25'h0, float_status_register}, 32'h7d);
        chk({31'h0, irq}, 32'h1);
        rdc(fpu_par_pkg::OFF_INT_STAT, 32'h1);
        wr(fpu_par_pkg::OFF_INT_STAT, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(fpu_par_pkg::OFF_INT_MASK, 32'h1);
        ld(3'h1, 32'h0080_0000);
        go(op(fpu_par_pkg::OP_MUL_STORE, 24'h000511, 4'h0, 16'h0));
        repeat (2) @(negedge CLK);
        chk({25'h0, float_status_register}, 32'h7f);
        chk({31'h0, irq}, 32'h0);
        rdc(fpu_par_pkg::OFF_INT_STAT, 32'h2);
        wr(fpu_par_pkg::OFF_INT_MASK, 32'h3);
        chk({31'h0, irq}, 32'h1);
        wr(fpu_par_pkg::OFF_INT_STAT, 32'h2);
        chk({31'h0, irq}, 32'h0);
        for (int i = 0; i < 32; i++) begin
            v = (i == 31) ? 32'h0 : $urandom;
            s = 7'($urandom);
            ld(3'h1, v);
            wr(fpu_par_pkg::OFF_STF, {25'h0, s});
            go(op(fpu_par_pkg::OP_COND_NEG, 24'h610000, i[3:0], 16'h0));
            e = cnd(i[3:0], s) ? {~v[31], v[30:0]} : v;
            st(3'h6, e);
            rdc(fpu_par_pkg::OFF_STF,
                {25'h0, (i[3:0] == 4'hf) ? upd(s, e) : s});
        end
        wr(fpu_par_pkg::OFF_STF, 32'h55);
        go(op(fpu_par_pkg::OP_NONE, 24'h0, 4'h0, fpu_par_pkg::OPC_POP_RB));
        rdc(fpu_par_pkg::OFF_RB, SEED);
        pl(4'h2);
        rdc(fpu_par_pkg::OFF_RA, 32'h1);
        for (int i = 0; i < 2; i++) begin
            go(op(fpu_par_pkg::OP_NONE, 24'h0, 4'h0,
                fpu_par_pkg::OPC_PUSH_RB));
            @(negedge CLK);
            chk({30'h0, stk.push, stall}, (i == 0) ? 32'h3 : 32'h2);
            chk(stk.wdata, SEED);
        end
        pl(4'h8);
        rdc(fpu_par_pkg::OFF_RA, 32'h2);
        pl(4'h4);
        rdc(fpu_par_pkg::OFF_RA, 32'h1);
        rdc(fpu_par_pkg::OFF_STF, 32'h55);
        pl(4'h1);
        ld(3'h1, 32'h1111_2222);
        wr(fpu_par_pkg::OFF_STF, 32'h15);
        go(op(fpu_par_pkg::OP_SAVE, 24'h0, 4'h0, 16'h0));
        ld(3'h1, 32'h3333_4444);
        wr(fpu_par_pkg::OFF_STF, 32'h6a);
        // no multiply in flight ahead of the restore
        go(op(fpu_par_pkg::OP_NONE, 24'h0, 4'h0,
            fpu_par_pkg::OPC_RESTORE));
        rdc(fpu_par_pkg::OFF_STF, 32'h15);
        st(3'h1, 32'h1111_2222);
        give_verdict();
    end
endmodule // tb
`default_nettype wire
